// ==== hw/tpls_map.svh ====
`ifndef TPLS_MAP_SVH
`define TPLS_MAP_SVH

// Pixel bus and line geometry
`define PIX_W           12
`define COL_W           13
`define FIFO_DEPTH      16

// Synthetic image values per output depth
`define GRAY_8          12'h07f
`define GRAY_10         12'h1ff
`define GRAY_12         12'h7ff

// Stamp layout
`define STAMP_COUNT     16
`define STAMP_IDX_W     4
`define STAMP_MARK_S1   8'haa
`define STAMP_MARK_A    8'h55
`define STAMP_MARK_B    8'h57
`define STAMP_RSVD      8'h00

// Statistic widths
`define SUM_W           24
`define CNT_W           16
`define CONTRAST_W      24

`endif

// ==== hw/tpls_pkg.sv ====
package tpls_pkg;

    typedef enum logic [1:0] {
        TI_SENSOR,
        TI_RAMP,
        TI_BLACK,
        TI_GRAY
    } test_image_t;

    typedef enum logic [1:0] {
        DEPTH_8,
        DEPTH_10,
        DEPTH_12,
        DEPTH_RSVD
    } depth_t;

    typedef struct packed {
        logic [11:0] value;
        logic        eol;
        logic        line_b;
    } pix_word_t;

endpackage

// ==== hw/pix_fifo.sv ====
`timescale 1ns/10ps
module pix_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_r;
    logic [AW:0]      wr_nxt;
    logic [AW:0]      rd_r;
    logic [AW:0]      rd_nxt;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    always_comb begin
        full      = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
        empty     = (wr_r == rd_r);
        in_ready  = !full;
        out_valid = !empty;
        out_data  = mem[rd_r[AW-1:0]];
        push      = in_valid && !full;
        pop       = out_ready && !empty;
        wr_nxt    = push ? wr_r + 1'b1 : wr_r;
        rd_nxt    = pop ? rd_r + 1'b1 : rd_r;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    // Storage has no reset; only entries between the pointers are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r[AW-1:0]] <= in_data;
        end
    end

endmodule

// ==== hw/line_stamp_gen.sv ====
`timescale 1ns/10ps
`include "tpls_map.svh"
module line_stamp_gen (
    input  wire logic                 MCLK,
    input  wire logic                 RESET,
    input  wire logic [`PIX_W-1:0]    SENSOR_PIXEL,
    input  wire logic                 SENSOR_VALID,
    input  wire logic                 SENSOR_LAST,
    input  wire logic                 SENSOR_LINE_B,
    output logic                      SENSOR_READY,
    input  wire logic                 EXTERNAL_LINE_TRIGGER,
    input  wire logic                 LINE_CTRL_PULSE,
    input  wire logic [1:0]           TEST_IMAGE,
    input  wire logic [1:0]           DEPTH_MODE,
    input  wire logic                 STAMP_EN,
    input  wire logic                 DUAL_LINE_MODE,
    input  wire logic                 PIXEL_WINDOW_EN,
    input  wire logic [`COL_W-1:0]    PIXEL_WINDOW_START,
    input  wire logic [`COL_W-1:0]    PIXEL_WINDOW_LEN,
    input  wire logic [`PIX_W-1:0]    HIGH_THRESH,
    input  wire logic [`PIX_W-1:0]    LOW_LIMIT,
    output logic      [`PIX_W-1:0]    PIX_DATA,
    output logic                      LINE_VALID,
    output logic                      DATA_VALID,
    input  wire logic                 OUT_READY
);

    typedef enum logic {ST_PIX, ST_STAMP} out_state_t;

    tpls_pkg::test_image_t test_mode;
    tpls_pkg::depth_t      depth;
    tpls_pkg::pix_word_t   in_word;
    tpls_pkg::pix_word_t   q_word;

    assign test_mode = tpls_pkg::test_image_t'(TEST_IMAGE);
    assign depth     = tpls_pkg::depth_t'(DEPTH_MODE);

    function automatic logic [`PIX_W-1:0] fmt8(input logic [7:0] b, input tpls_pkg::depth_t d);
        case (d)
            tpls_pkg::DEPTH_10: fmt8 = {2'h0, b, 2'h0};
            tpls_pkg::DEPTH_12: fmt8 = {b, 4'h0};
            default:            fmt8 = {4'h0, b};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Line trigger: pin is asynchronous, so two flops before the edge detector

    logic       trig_s1_r;
    logic       trig_s2_r;
    logic       trig_s3_r;
    logic       trig_evt;
    logic [7:0] ramp_r;
    logic [7:0] ramp_nxt;

    always_comb begin
        trig_evt = (trig_s2_r && !trig_s3_r) || LINE_CTRL_PULSE;
        ramp_nxt = trig_evt ? ramp_r + 8'h01 : ramp_r;
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;
            ramp_r    <= 8'h00;
        end else begin
            trig_s1_r <= EXTERNAL_LINE_TRIGGER;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
            ramp_r    <= ramp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input side: image source, pixel window, push into the FIFO

    logic [`COL_W-1:0] col_r;
    logic [`COL_W-1:0] col_nxt;
    logic [`COL_W:0]   pix_num;
    logic [`COL_W:0]   win_end;
    logic              in_win;
    logic              win_last;
    logic              fifo_in_ready;
    logic              push;
    logic [7:0]        grad;
    logic [`PIX_W-1:0] src_val;

    always_comb begin
        pix_num  = {1'b0, col_r} + 14'h0001;
        win_end  = {1'b0, PIXEL_WINDOW_START} + {1'b0, PIXEL_WINDOW_LEN} - 14'h0001;
        in_win   = !PIXEL_WINDOW_EN ||
                   (pix_num >= {1'b0, PIXEL_WINDOW_START} && pix_num <= win_end);
        win_last = PIXEL_WINDOW_EN && (pix_num == win_end);
        grad     = ramp_r + col_r[7:0];
        case (test_mode)
            tpls_pkg::TI_RAMP: begin
                case (depth)
                    tpls_pkg::DEPTH_10: src_val = {2'h0, grad, grad[7:6]};
                    tpls_pkg::DEPTH_12: src_val = {grad, grad[7:4]};
                    default:            src_val = {4'h0, grad};
                endcase
            end
            tpls_pkg::TI_BLACK: src_val = '0;
            tpls_pkg::TI_GRAY: begin
                case (depth)
                    tpls_pkg::DEPTH_10: src_val = `GRAY_10;
                    tpls_pkg::DEPTH_12: src_val = `GRAY_12;
                    default:            src_val = `GRAY_8;
                endcase
            end
            default: begin
                case (depth)
                    tpls_pkg::DEPTH_10: src_val = {2'h0, SENSOR_PIXEL[11:2]};
                    tpls_pkg::DEPTH_12: src_val = SENSOR_PIXEL;
                    default:            src_val = {4'h0, SENSOR_PIXEL[11:4]};
                endcase
            end
        endcase
        in_word.value  = src_val;
        in_word.eol    = SENSOR_LAST || win_last;
        in_word.line_b = DUAL_LINE_MODE && SENSOR_LINE_B;
        SENSOR_READY   = fifo_in_ready;
        push           = SENSOR_VALID && in_win;
        if (SENSOR_VALID && fifo_in_ready) begin
            col_nxt = SENSOR_LAST ? '0 : col_r + 13'h0001;
        end else begin
            col_nxt = col_r;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            col_r <= '0;
        end else begin
            col_r <= col_nxt;
        end
    end

    logic q_valid;
    logic q_ready;

    pix_fifo #(
        .WIDTH ($bits(tpls_pkg::pix_word_t)),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clk       (MCLK),
        .rst       (RESET),
        .in_data   (in_word),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .out_data  (q_word),
        .out_valid (q_valid),
        .out_ready (q_ready)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Output side: pixels, statistics and the stamp sequence

    out_state_t              state_r;
    out_state_t              state_nxt;
    logic [`PIX_W-1:0]       data_r;
    logic [`PIX_W-1:0]       data_nxt;
    logic                    dv_r;
    logic                    dv_nxt;
    logic                    inline_r;
    logic                    inline_nxt;
    logic [`STAMP_IDX_W-1:0] idx_r;
    logic [`STAMP_IDX_W-1:0] idx_nxt;
    logic                    line_b_r;
    logic                    line_b_nxt;
    logic                    first_r;
    logic                    first_nxt;
    logic [`PIX_W-1:0]       prev_r;
    logic [`PIX_W-1:0]       prev_nxt;
    logic [`SUM_W-1:0]       sum_r;
    logic [`SUM_W-1:0]       sum_nxt;
    logic [`CNT_W-1:0]       high_r;
    logic [`CNT_W-1:0]       high_nxt;
    logic [`CNT_W-1:0]       low_r;
    logic [`CNT_W-1:0]       low_nxt;
    logic [`CONTRAST_W-1:0]  con_r;
    logic [`CONTRAST_W-1:0]  con_nxt;
    logic [`CNT_W-1:0]       lcnt_r;
    logic [`CNT_W-1:0]       lcnt_nxt;
    logic                    load_ok;
    logic                    pop;
    logic [`PIX_W-1:0]       diff;
    logic [7:0]              stamp_byte;

    always_comb begin
        case (idx_r)
            4'h0:    stamp_byte = `STAMP_MARK_S1;
            4'h1:    stamp_byte = line_b_r ? `STAMP_MARK_B : `STAMP_MARK_A;
            4'h2:    stamp_byte = lcnt_r[7:0];
            4'h3:    stamp_byte = lcnt_r[15:8];
            4'h4:    stamp_byte = sum_r[7:0];
            4'h5:    stamp_byte = sum_r[15:8];
            4'h6:    stamp_byte = sum_r[23:16];
            4'h8:    stamp_byte = high_r[7:0];
            4'h9:    stamp_byte = high_r[15:8];
            4'ha:    stamp_byte = low_r[7:0];
            4'hb:    stamp_byte = low_r[15:8];
            4'hc:    stamp_byte = con_r[7:0];
            4'hd:    stamp_byte = con_r[15:8];
            4'he:    stamp_byte = con_r[23:16];
            default: stamp_byte = `STAMP_RSVD;
        endcase
    end

    always_comb begin
        load_ok    = !dv_r || OUT_READY;
        q_ready    = load_ok && (state_r == ST_PIX);
        pop        = q_ready && q_valid;
        diff       = (q_word.value > prev_r) ? q_word.value - prev_r : prev_r - q_word.value;
        state_nxt  = state_r;
        data_nxt   = data_r;
        dv_nxt     = dv_r && !OUT_READY;
        inline_nxt = inline_r;
        idx_nxt    = idx_r;
        line_b_nxt = line_b_r;
        first_nxt  = first_r;
        prev_nxt   = prev_r;
        sum_nxt    = sum_r;
        high_nxt   = high_r;
        low_nxt    = low_r;
        con_nxt    = con_r;
        lcnt_nxt   = lcnt_r;
        case (state_r)
            ST_PIX: begin
                if (pop) begin
                    data_nxt   = q_word.value;
                    dv_nxt     = 1'b1;
                    inline_nxt = !q_word.eol || STAMP_EN;
                    first_nxt  = q_word.eol;
                    prev_nxt   = q_word.value;
                    line_b_nxt = q_word.line_b;
                    sum_nxt    = sum_r + {12'h000, q_word.value};
                    if (q_word.value > HIGH_THRESH) begin
                        high_nxt = high_r + 16'h0001;
                    end
                    if (q_word.value < LOW_LIMIT) begin
                        low_nxt = low_r + 16'h0001;
                    end
                    if (!first_r) begin
                        con_nxt = con_r + {12'h000, diff};
                    end
                    if (q_word.eol) begin
                        if (STAMP_EN) begin
                            state_nxt = ST_STAMP;
                            idx_nxt   = '0;
                        end else begin
                            sum_nxt  = '0;
                            high_nxt = '0;
                            low_nxt  = '0;
                            con_nxt  = '0;
                        end
                    end
                end
            end
            ST_STAMP: begin
                if (load_ok) begin
                    data_nxt = fmt8(stamp_byte, depth);
                    dv_nxt   = 1'b1;
                    idx_nxt  = idx_r + 4'h1;
                    if (idx_r == 4'(`STAMP_COUNT - 1)) begin
                        state_nxt  = ST_PIX;
                        inline_nxt = 1'b0;
                        lcnt_nxt   = lcnt_r + 16'h0001;
                        sum_nxt    = '0;
                        high_nxt   = '0;
                        low_nxt    = '0;
                        con_nxt    = '0;
                    end
                end
            end
            default: state_nxt = ST_PIX;
        endcase
        if (!STAMP_EN) begin
            lcnt_nxt = '0;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            state_r  <= ST_PIX;
            data_r   <= '0;
            dv_r     <= 1'b0;
            inline_r <= 1'b0;
            idx_r    <= '0;
            line_b_r <= 1'b0;
            first_r  <= 1'b1;
            prev_r   <= '0;
            sum_r    <= '0;
            high_r   <= '0;
            low_r    <= '0;
            con_r    <= '0;
            lcnt_r   <= '0;
        end else begin
            state_r  <= state_nxt;
            data_r   <= data_nxt;
            dv_r     <= dv_nxt;
            inline_r <= inline_nxt;
            idx_r    <= idx_nxt;
            line_b_r <= line_b_nxt;
            first_r  <= first_nxt;
            prev_r   <= prev_nxt;
            sum_r    <= sum_nxt;
            high_r   <= high_nxt;
            low_r    <= low_nxt;
            con_r    <= con_nxt;
            lcnt_r   <= lcnt_nxt;
        end
    end

    // Line valid stays high across FIFO gaps inside a line
    assign LINE_VALID = inline_r || dv_r;
    assign DATA_VALID = dv_r;
    assign PIX_DATA   = data_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    sequence s_eol_pop;
        pop && q_word.eol && STAMP_EN;
    endsequence

    sequence s_stamp_run;
        (state_r == ST_STAMP) [*8];
    endsequence

    property p_stamp_follows;
        s_eol_pop |=> s_stamp_run;
    endproperty
    a_stamp_follows: assert property (p_stamp_follows)
        else $error("stamp did not follow line end");

    property p_direct_after;
        s_eol_pop ##1 load_ok |=> dv_r && data_r == fmt8(`STAMP_MARK_S1, $past(depth));
    endproperty
    a_direct_after: assert property (p_direct_after)
        else $error("first stamp not directly after last pixel");

    property p_marker;
        state_r == ST_STAMP && load_ok && idx_r == 4'h0 |=> data_r[11:4] == 8'haa
            || data_r[9:2] == 8'haa || data_r[7:0] == 8'haa;
    endproperty
    a_marker: assert property (p_marker)
        else $error("stamp marker wrong");

    property p_reserved;
        state_r == ST_STAMP && load_ok && (idx_r == 4'h7 || idx_r == 4'hf) |=> data_r == '0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved stamp not zero");

    property p_low_bits;
        state_r == ST_STAMP && load_ok && depth == tpls_pkg::DEPTH_12 |=> data_r[3:0] == 4'h0;
    endproperty
    a_low_bits: assert property (p_low_bits)
        else $error("stamp low bits not zero");

    property p_valid_in_stamp;
        state_r == ST_STAMP |-> LINE_VALID;
    endproperty
    a_valid_in_stamp: assert property (p_valid_in_stamp)
        else $error("line valid dropped during stamp");

    property p_ramp_step;
        trig_evt |=> ramp_r == $past(ramp_r) + 8'h01;
    endproperty
    a_ramp_step: assert property (p_ramp_step)
        else $error("ramp start did not advance");

    property p_black;
        push && test_mode == tpls_pkg::TI_BLACK |-> in_word.value == '0;
    endproperty
    a_black: assert property (p_black)
        else $error("black image not zero");

    property p_gray8;
        push && test_mode == tpls_pkg::TI_GRAY && depth == tpls_pkg::DEPTH_8
            |-> in_word.value == 12'h07f;
    endproperty
    a_gray8: assert property (p_gray8)
        else $error("gray level wrong");

    property p_cnt_clear;
        !STAMP_EN |=> lcnt_r == '0;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear)
        else $error("line counter not cleared");

endmodule

// ==== testbench/grabber_model.sv ====
`timescale 1ns/10ps
`include "tpls_map.svh"
module grabber_model (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [`PIX_W-1:0] pix,
    input  wire logic              dvalid,
    input  wire logic              lvalid,
    input  wire logic [1:0]        stall,
    output logic                   ready
);
    logic [`PIX_W-1:0] got [0:1023];
    int                cyc [0:1023];
    int                n_got;
    int                lv_bad;
    int                tick;
    logic              ph;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode 0 always ready, 1 every other cycle, 2 refuses so the FIFO backs up
    assign ready = (stall == 2'h0) || ((stall == 2'h1) && ph);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ph <= 1'b0;
            tick <= 0;
            n_got <= 0;
            lv_bad <= 0;
        end else begin
            ph <= ~ph;
            tick <= tick + 1;
            if (dvalid && ready) begin
                got[n_got] <= pix;
                cyc[n_got] <= tick;
                n_got <= n_got + 1;
                if (lvalid !== 1'b1) begin
                    lv_bad <= lv_bad + 1;
                end
            end
        end
    end
endmodule

// ==== testbench/test_pattern_and_line_stamp_test.sv ====
`timescale 1ns/10ps
`include "tpls_map.svh"
module test_pattern_and_line_stamp_test;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [11:0] s_pix = 12'h000;
    logic        s_valid = 1'b0;
    logic        s_last = 1'b0;
    logic        s_lb = 1'b0;
    logic        s_ready;
    logic        ext_trig = 1'b0;
    logic        ctrl_pulse = 1'b0;
    logic [1:0]  test_image = 2'h0;
    logic [1:0]  depth = 2'h0;
    logic        stamp_en = 1'b0;
    logic        dual = 1'b0;
    logic        win_en = 1'b0;
    logic [12:0] win_start = 13'h0001;
    logic [12:0] win_len = 13'h0001;
    logic [11:0] hi_th = 12'h060;
    logic [11:0] lo_lim = 12'h020;
    logic [11:0] pix_data;
    logic        line_valid;
    logic        data_valid;
    logic        out_ready;
    logic [1:0]  stall = 2'h0;
    logic [11:0] spix [0:7] = '{12'h100, 12'h7f0, 12'h150, 12'h900,
                                12'h0a0, 12'h330, 12'h050, 12'hfff};
    logic [11:0] exp_q [$];
    int          err_count = 0;
    int          n_tests = 0;
    int          rd = 0;

    always #2.5 mclk = ~mclk;

    line_stamp_gen line_stamp_gen_i (.MCLK(mclk), .RESET(reset), .SENSOR_PIXEL(s_pix),
        .SENSOR_VALID(s_valid), .SENSOR_LAST(s_last), .SENSOR_LINE_B(s_lb),
        .SENSOR_READY(s_ready), .EXTERNAL_LINE_TRIGGER(ext_trig),
        .LINE_CTRL_PULSE(ctrl_pulse), .TEST_IMAGE(test_image), .DEPTH_MODE(depth),
        .STAMP_EN(stamp_en), .DUAL_LINE_MODE(dual), .PIXEL_WINDOW_EN(win_en),
        .PIXEL_WINDOW_START(win_start), .PIXEL_WINDOW_LEN(win_len), .HIGH_THRESH(hi_th),
        .LOW_LIMIT(lo_lim), .PIX_DATA(pix_data), .LINE_VALID(line_valid),
        .DATA_VALID(data_valid), .OUT_READY(out_ready));

    grabber_model grabber_model_i (.clk(mclk), .rst(reset), .pix(pix_data),
        .dvalid(data_valid), .lvalid(line_valid), .stall(stall), .ready(out_ready));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [11:0] e, input logic [11:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t word %0d got %h expected %h", $time, rd, g, e);
        end
    endtask

    function automatic logic [11:0] dep(input logic [11:0] p);
        case (depth)
            2'h1: return {2'h0, p[11:2]};
            2'h2: return p;
            default: return {4'h0, p[11:4]};
        endcase
    endfunction

    function automatic logic [11:0] sb(input logic [7:0] b);
        case (depth)
            2'h1: return {2'h0, b, 2'h0};
            2'h2: return {b, 4'h0};
            default: return {4'h0, b};
        endcase
    endfunction

    function automatic logic [11:0] ramp(input int s, input int i);
        logic [7:0] g;
        g = 8'(s + i);
        case (depth)
            2'h1: return {2'h0, g, g[7:6]};
            2'h2: return {g, g[7:4]};
            default: return {4'h0, g};
        endcase
    endfunction

    // Entered at a falling edge; each pixel is held until a rising edge sees ready
    task automatic push_line(input int n, input logic lb);
        int k;
        for (int i = 0; i < n; i++) begin
            s_pix = spix[i % 8];
            s_valid = 1'b1;
            s_last = (i == n - 1);
            s_lb = lb;
            k = 0;
            while (s_ready !== 1'b1 && k < 300) begin
                @(negedge mclk);
                k++;
            end
            if (k == 300) begin
                err_count++;
                results();
            end
            @(negedge mclk);
        end
        s_valid = 1'b0;
        s_last = 1'b0;
    endtask

    task automatic drain();
        int k = 0;
        while (grabber_model_i.n_got < rd + exp_q.size() && k < 3000) begin
            @(negedge mclk);
            k++;
        end
        if (k == 3000) begin
            err_count++;
            results();
        end
        while (exp_q.size() > 0) begin
            chk(exp_q.pop_front(), grabber_model_i.got[rd]);
            rd++;
        end
        repeat (3) @(negedge mclk);
    endtask

    // Builds the expected window words and stamp, then sends an eight pixel line
    task automatic stamped(input int ws, input int wl, input logic [15:0] cnt, input logic lb);
        logic [23:0] sum;
        logic [23:0] ct;
        logic [15:0] hc;
        logic [15:0] lc;
        logic [11:0] v;
        logic [11:0] pv;
        logic [7:0]  st [0:15];
        sum = '0;
        ct = '0;
        hc = '0;
        lc = '0;
        pv = '0;
        win_start = 13'(ws);
        win_len = 13'(wl);
        for (int i = ws; i < ws + wl; i++) begin
            v = dep(spix[i-1]);
            exp_q.push_back(v);
            sum += 24'(v);
            if (v > hi_th) hc++;
            if (v < lo_lim) lc++;
            if (i > ws) ct += 24'((v > pv) ? v - pv : pv - v);
            pv = v;
        end
        st = '{8'haa, (dual && lb) ? 8'h57 : 8'h55, cnt[7:0], cnt[15:8], sum[7:0],
               sum[15:8], sum[23:16], 8'h00, hc[7:0], hc[15:8], lc[7:0], lc[15:8],
               ct[7:0], ct[15:8], ct[23:16], 8'h00};
        if (stamp_en) foreach (st[j]) exp_q.push_back(sb(st[j]));
        push_line(8, lb);
        drain();
        if (stamp_en && stall == 2'h0)
            chk(12'h010, 12'(grabber_model_i.cyc[rd-1] - grabber_model_i.cyc[rd-17]));
        chk(12'h000, 12'(grabber_model_i.lv_bad));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int k;
        repeat (3) @(negedge mclk);
        reset = 1'b0;
        test_image = tpls_pkg::TI_RAMP;
        for (int i = 0; i < 300; i++) exp_q.push_back(ramp(0, i));
        push_line(300, 1'b0);
        drain();
        ctrl_pulse = 1'b1;
        @(negedge mclk);
        ctrl_pulse = 1'b0;
        depth = tpls_pkg::DEPTH_10;
        for (int i = 0; i < 20; i++) exp_q.push_back(ramp(1, i));
        push_line(20, 1'b0);
        drain();
        ext_trig = 1'b1;
        repeat (4) @(negedge mclk);
        ext_trig = 1'b0;
        repeat (4) @(negedge mclk);
        depth = tpls_pkg::DEPTH_12;
        for (int i = 0; i < 20; i++) exp_q.push_back(ramp(2, i));
        push_line(20, 1'b0);
        drain();
        for (int t = 2; t < 4; t++) begin
            for (int d = 0; d < 3; d++) begin
                test_image = 2'(t);
                depth = 2'(d);
                for (int i = 0; i < 4; i++)
                    exp_q.push_back((t == 2) ? 12'h000 :
                        (d == 0) ? `GRAY_8 : (d == 1) ? `GRAY_10 : `GRAY_12);
                push_line(4, 1'b0);
                drain();
            end
        end
        test_image = tpls_pkg::TI_SENSOR;
        depth = tpls_pkg::DEPTH_8;
        stamp_en = 1'b1;
        win_en = 1'b1;
        stamped(3, 4, 16'h0000, 1'b0);
        dual = 1'b1;
        depth = tpls_pkg::DEPTH_10;
        stamped(2, 6, 16'h0001, 1'b1);
        depth = tpls_pkg::DEPTH_12;
        win_en = 1'b0;
        stamped(1, 8, 16'h0002, 1'b0);
        stamp_en = 1'b0;
        stamped(1, 8, 16'h0000, 1'b0);
        stamp_en = 1'b1;
        stall = 2'h1;
        stamped(1, 8, 16'h0000, 1'b1);
        stall = 2'h2;
        stamp_en = 1'b0;
        test_image = tpls_pkg::TI_BLACK;
        for (int i = 0; i < 40; i++) exp_q.push_back(12'h000);
        fork
            push_line(40, 1'b0);
            begin
                k = 0;
                while (s_ready !== 1'b0 && k < 100) begin
                    @(negedge mclk);
                    k++;
                end
                chk(12'h000, {11'h000, s_ready});
                repeat (10) @(negedge mclk);
                stall = 2'h1;
            end
        join
        drain();
        stall = 2'h0;
        results();
    end
endmodule
